//--- src/eag_pkg.sv
package eag_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int ADDR_W = 64;
  localparam int SEL_W = 16;
  localparam int GPR_IDX_W = 4;
  localparam int SEG_IDX_W = 3;

  // ****************************************************************
  // Register numbers
  // ****************************************************************
  localparam logic [3:0] REG_STACK_PTR = 4'h4;
  localparam logic [3:0] REG_FRAME_PTR = 4'h5;

  // ****************************************************************
  // Far pointer layout
  // ****************************************************************
  localparam int FAR_OFS_LSB = 0;
  localparam int FAR_OFS_W = 32;
  localparam int FAR_SEL_LSB = 32;
  localparam int FAR_PTR_W = 48;

  // ****************************************************************
  // Enumerations
  // ****************************************************************
  typedef enum logic [2:0] {
    EAG_SEG_STRING, EAG_SEG_CODE, EAG_SEG_STACK, EAG_SEG_DATA, EAG_SEG_EXTRA_A, EAG_SEG_EXTRA_B
  } eag_seg_type;

  typedef enum logic [1:0] {
    EAG_MODE_LEGACY, EAG_MODE_COMPAT, EAG_MODE_LONG64
  } eag_mode_type;

  typedef enum logic [1:0] {
    EAG_ASZ_16, EAG_ASZ_32, EAG_ASZ_64
  } eag_asize_type;

  typedef enum logic [1:0] {
    EAG_DISP_NONE, EAG_DISP_8, EAG_DISP_16, EAG_DISP_32
  } eag_disp_type;

  typedef enum logic [1:0] {
    EAG_SCALE_1, EAG_SCALE_2, EAG_SCALE_4, EAG_SCALE_8
  } eag_scale_type;

  typedef enum logic [2:0] {
    EAG_REF_DATA, EAG_REF_FETCH, EAG_REF_PUSHPOP, EAG_REF_STRING_DST, EAG_REF_FAR_PTR
  } eag_ref_type;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic valid;
    eag_ref_type ref_kind;
    eag_mode_type mode;
    eag_asize_type asize;
    logic wide_operand_flag;
    logic base_en;
    logic [GPR_IDX_W-1:0] base_idx;
    logic index_en;
    logic [GPR_IDX_W-1:0] index_idx;
    eag_scale_type scale;
    eag_disp_type disp_kind;
    logic [31:0] disp;
    logic ip_rel;
    logic override_en;
    eag_seg_type override_seg;
  } eag_req_type;

  typedef struct packed {
    logic valid;
    logic fault;
    eag_seg_type seg;
    logic [SEL_W-1:0] selector;
    logic [ADDR_W-1:0] eff_addr;
    logic [ADDR_W-1:0] lin_addr;
  } eag_resp_type;

endpackage

//--- src/eag_seg_table.sv
`timescale 1ns/1ps
`default_nettype none

// Segment base and selector store, written by segment loads, read registered
module eag_seg_table
  import eag_pkg::*;
#(
  parameter int NUM_SEG = 6
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic wr_en_in,
  input wire logic [SEG_IDX_W-1:0] wr_idx_in,
  input wire logic [SEL_W-1:0] wr_sel_in,
  input wire logic [ADDR_W-1:0] wr_base_in,
  input wire logic [SEG_IDX_W-1:0] rd_idx_in,
  output logic [SEL_W-1:0] rd_sel_out,
  output logic [ADDR_W-1:0] rd_base_out
);

  logic [SEL_W-1:0] sel_mem [NUM_SEG];
  logic [ADDR_W-1:0] base_mem [NUM_SEG];

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NUM_SEG; i++) begin
        sel_mem[i] <= '0;
        base_mem[i] <= '0;
      end
      rd_sel_out <= '0;
      rd_base_out <= '0;
    end else begin
      if (wr_en_in) begin
        sel_mem[wr_idx_in] <= wr_sel_in;
        base_mem[wr_idx_in] <= wr_base_in;
      end
      rd_sel_out <= sel_mem[rd_idx_in];
      rd_base_out <= base_mem[rd_idx_in];
    end
  end

endmodule

`default_nettype wire

//--- src/eag_offset_adder.sv
`timescale 1ns/1ps
`default_nettype none

// Sums base, scaled index and displacement, truncated to the address size
module eag_offset_adder
  import eag_pkg::*;
(
  input wire logic base_en_in,
  input wire logic [ADDR_W-1:0] base_in,
  input wire logic index_en_in,
  input wire logic [ADDR_W-1:0] index_in,
  input wire eag_scale_type scale_in,
  input wire logic [ADDR_W-1:0] disp_in,
  input wire eag_asize_type asize_in,
  output logic [ADDR_W-1:0] sum_out
);

  function automatic logic [ADDR_W-1:0] trunc_asize(input logic [ADDR_W-1:0] v,
                                                    input eag_asize_type a);
    case (a)
      EAG_ASZ_16: trunc_asize = {48'h0, v[15:0]};
      EAG_ASZ_32: trunc_asize = {32'h0, v[31:0]};
      default: trunc_asize = v;
    endcase
  endfunction

  logic [ADDR_W-1:0] scaled;
  logic [ADDR_W-1:0] raw;

  always_comb begin
    scaled = '0;
    if (index_en_in) begin
      scaled = index_in << scale_in;
    end
    raw = (base_en_in ? base_in : '0) + scaled + disp_in;
    sum_out = trunc_asize(raw, asize_in);
  end

endmodule

`default_nettype wire

//--- src/eag_core.sv
`timescale 1ns/1ps
`default_nettype none

module eag_core
  import eag_pkg::*;
#(
  parameter int NUM_GPR = 16
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire eag_req_type req_in,
  input wire logic [NUM_GPR*ADDR_W-1:0] gpr_in,
  input wire logic [ADDR_W-1:0] next_instr_pointer_in,
  input wire logic [FAR_PTR_W-1:0] far_ptr_in,
  input wire logic seg_wr_en_in,
  input wire eag_seg_type seg_wr_idx_in,
  input wire logic [SEL_W-1:0] seg_wr_sel_in,
  input wire logic [ADDR_W-1:0] seg_wr_base_in,
  output eag_resp_type resp_out
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [ADDR_W-1:0] read_gpr(input logic [GPR_IDX_W-1:0] idx,
                                                 input eag_mode_type m,
                                                 input logic wide,
                                                 input logic [NUM_GPR*ADDR_W-1:0] file);
    logic [ADDR_W-1:0] v;
    v = file[idx*ADDR_W +: ADDR_W];
    if (m == EAG_MODE_LONG64 && wide) begin
      read_gpr = v;
    end else begin
      read_gpr = {{32{v[31]}}, v[31:0]};
    end
  endfunction

  function automatic logic [ADDR_W-1:0] ext_disp(input eag_disp_type k,
                                                 input logic [31:0] d);
    case (k)
      EAG_DISP_8: ext_disp = {{56{d[7]}}, d[7:0]};
      EAG_DISP_16: ext_disp = {{48{d[15]}}, d[15:0]};
      EAG_DISP_32: ext_disp = {{32{d[31]}}, d};
      default: ext_disp = '0;
    endcase
  endfunction

  // ****************************************************************
  // Segment selection, stage 0
  // ****************************************************************
  eag_seg_type seg_sel;
  logic idx_fault;
  logic base_is_stack;
  logic long_flat;
  eag_asize_type asize_eff;

  always_comb begin
    base_is_stack = req_in.base_en &&
                    (req_in.base_idx == REG_STACK_PTR || req_in.base_idx == REG_FRAME_PTR);
    seg_sel = base_is_stack ? EAG_SEG_STACK : EAG_SEG_DATA;
    case (req_in.ref_kind)
      EAG_REF_FETCH: seg_sel = EAG_SEG_CODE;
      EAG_REF_PUSHPOP: seg_sel = EAG_SEG_STACK;
      EAG_REF_STRING_DST: seg_sel = EAG_SEG_STRING;
      default: begin
        if (req_in.override_en) begin
          seg_sel = req_in.override_seg;
        end
      end
    endcase
    idx_fault = req_in.index_en && req_in.index_idx == REG_STACK_PTR;
    long_flat = req_in.mode == EAG_MODE_LONG64;
    asize_eff = req_in.asize;
    if (!long_flat && asize_eff == EAG_ASZ_64) begin
      asize_eff = EAG_ASZ_32;
    end
  end

  // ****************************************************************
  // Offset computation
  // ****************************************************************
  logic [ADDR_W-1:0] base_val;
  logic [ADDR_W-1:0] index_val;
  logic [ADDR_W-1:0] disp_val;
  logic [ADDR_W-1:0] ea_sum;
  logic use_base;
  logic use_index;

  always_comb begin
    use_base = req_in.base_en || req_in.ip_rel;
    use_index = req_in.index_en && !idx_fault && !req_in.ip_rel;
    base_val = read_gpr(req_in.base_idx, req_in.mode, req_in.wide_operand_flag, gpr_in);
    index_val = read_gpr(req_in.index_idx, req_in.mode, req_in.wide_operand_flag, gpr_in);
    disp_val = ext_disp(req_in.disp_kind, req_in.disp);
    if (req_in.ip_rel) begin
      base_val = next_instr_pointer_in;
      disp_val = {{32{req_in.disp[31]}}, req_in.disp};
    end
    if (req_in.ref_kind == EAG_REF_FAR_PTR) begin
      disp_val = {32'h0, far_ptr_in[FAR_OFS_LSB +: FAR_OFS_W]};
    end
  end

  eag_offset_adder u_adder (
    .base_en_in(use_base),
    .base_in(base_val),
    .index_en_in(use_index),
    .index_in(index_val),
    .scale_in(req_in.scale),
    .disp_in(disp_val),
    .asize_in(asize_eff),
    .sum_out(ea_sum)
  );

  // ****************************************************************
  // Stage 1 registers, aligned with the segment table read
  // ****************************************************************
  logic s1_valid, next_s1_valid;
  logic s1_fault, next_s1_fault;
  logic s1_flat, next_s1_flat;
  logic s1_far, next_s1_far;
  logic [SEL_W-1:0] s1_far_sel, next_s1_far_sel;
  eag_seg_type s1_seg, next_s1_seg;
  logic [ADDR_W-1:0] s1_ea, next_s1_ea;
  logic [SEL_W-1:0] tbl_sel;
  logic [ADDR_W-1:0] tbl_base;

  eag_seg_table u_table (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .wr_en_in(seg_wr_en_in),
    .wr_idx_in(seg_wr_idx_in),
    .wr_sel_in(seg_wr_sel_in),
    .wr_base_in(seg_wr_base_in),
    .rd_idx_in(seg_sel),
    .rd_sel_out(tbl_sel),
    .rd_base_out(tbl_base)
  );

  always_comb begin
    next_s1_valid = req_in.valid;
    next_s1_fault = req_in.valid && idx_fault;
    next_s1_flat = long_flat;
    next_s1_far = req_in.ref_kind == EAG_REF_FAR_PTR;
    next_s1_far_sel = far_ptr_in[FAR_SEL_LSB +: SEL_W];
    next_s1_seg = seg_sel;
    next_s1_ea = ea_sum;
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_valid <= 1'b0;
      s1_fault <= 1'b0;
      s1_flat <= 1'b0;
      s1_far <= 1'b0;
      s1_far_sel <= '0;
      s1_seg <= EAG_SEG_DATA;
      s1_ea <= '0;
    end else begin
      s1_valid <= next_s1_valid;
      s1_fault <= next_s1_fault;
      s1_flat <= next_s1_flat;
      s1_far <= next_s1_far;
      s1_far_sel <= next_s1_far_sel;
      s1_seg <= next_s1_seg;
      s1_ea <= next_s1_ea;
    end
  end

  // ****************************************************************
  // Linear address, stage 2 output
  // ****************************************************************
  eag_resp_type next_resp;
  logic [ADDR_W-1:0] seg_base;

  always_comb begin
    seg_base = tbl_base;
    if (s1_flat && s1_seg != EAG_SEG_EXTRA_A && s1_seg != EAG_SEG_EXTRA_B) begin
      seg_base = '0;
    end
    next_resp.valid = s1_valid;
    next_resp.fault = s1_fault;
    next_resp.seg = s1_seg;
    next_resp.selector = s1_far ? s1_far_sel : tbl_sel;
    next_resp.eff_addr = s1_ea;
    next_resp.lin_addr = s1_ea + seg_base;
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      resp_out <= '0;
    end else begin
      resp_out <= next_resp;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_fetch_req;
    req_in.valid && req_in.ref_kind == EAG_REF_FETCH;
  endsequence

  a_fetch_code_seg: assert property (s_fetch_req |-> ##2 resp_out.seg == EAG_SEG_CODE)
    else $error("fetch not on code segment");
  a_pushpop_stack: assert property (req_in.valid && req_in.ref_kind == EAG_REF_PUSHPOP
    |-> ##2 resp_out.seg == EAG_SEG_STACK)
    else $error("push or pop not on stack segment");
  a_string_dst_seg: assert property (req_in.valid && req_in.ref_kind == EAG_REF_STRING_DST
    |-> ##2 resp_out.seg == EAG_SEG_STRING)
    else $error("string destination segment wrong");
  a_stack_base_seg: assert property (req_in.valid && req_in.ref_kind == EAG_REF_DATA
    && !req_in.override_en && base_is_stack |-> ##2 resp_out.seg == EAG_SEG_STACK)
    else $error("stack base did not pick stack segment");
  a_override_data: assert property (req_in.valid && req_in.ref_kind == EAG_REF_DATA
    && req_in.override_en |-> ##2 resp_out.seg == $past(req_in.override_seg, 2))
    else $error("override not applied");
  a_stack_index_fault: assert property (req_in.valid && req_in.index_en
    && req_in.index_idx == REG_STACK_PTR |-> ##2 resp_out.fault)
    else $error("stack pointer index not flagged");
  a_flat_linear: assert property (resp_out.valid && $past(s1_flat)
    && resp_out.seg inside {EAG_SEG_CODE, EAG_SEG_DATA, EAG_SEG_STACK, EAG_SEG_STRING}
    |-> resp_out.lin_addr == resp_out.eff_addr)
    else $error("flat linear differs from effective");
  a_addr16_trunc: assert property (req_in.valid && req_in.asize == EAG_ASZ_16
    |-> ##2 resp_out.eff_addr[ADDR_W-1:16] == '0)
    else $error("16-bit address not truncated");

endmodule

`default_nettype wire

//--- verif/eag_gpr_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// General register file in front of the address generator
// ****************************************************************
module eag_gpr_model
  import eag_pkg::*;
(
  input wire logic clock_in,
  input wire logic wr_en_in,
  input wire logic [GPR_IDX_W-1:0] wr_idx_in,
  input wire logic [ADDR_W-1:0] wr_data_in,
  output logic [16*ADDR_W-1:0] gpr_out
);
  logic [ADDR_W-1:0] regs [16];

  always_ff @(posedge clock_in) begin
    if (wr_en_in) begin
      regs[wr_idx_in] <= wr_data_in;
    end
  end

  always_comb begin
    for (int i = 0; i < 16; i++) begin
      gpr_out[i*ADDR_W +: ADDR_W] = regs[i];
    end
  end
endmodule

`default_nettype wire

//--- verif/effective_address_gen_tb.sv
`timescale 1ns/1ps
`default_nettype none

module effective_address_gen_tb;
  import eag_pkg::*;
  logic clock_in;
  logic rst_n_in;
  eag_req_type req;
  eag_resp_type resp;
  logic [16*ADDR_W-1:0] gpr;
  logic [63:0] nip;
  logic [47:0] far;
  logic seg_wr_en;
  eag_seg_type seg_wr_idx;
  logic [15:0] seg_wr_sel;
  logic [63:0] seg_wr_base;
  logic gw_en;
  logic [3:0] gw_idx;
  logic [63:0] gw_data;
  logic [63:0] gv [16];
  int errors;
  int tests_run;

  eag_core eag_core_i (.clock_in(clock_in), .rst_n_in(rst_n_in), .req_in(req), .gpr_in(gpr),
    .next_instr_pointer_in(nip), .far_ptr_in(far), .seg_wr_en_in(seg_wr_en),
    .seg_wr_idx_in(seg_wr_idx), .seg_wr_sel_in(seg_wr_sel), .seg_wr_base_in(seg_wr_base),
    .resp_out(resp));
  eag_gpr_model eag_gpr_model_i (.clock_in(clock_in), .wr_en_in(gw_en), .wr_idx_in(gw_idx),
    .wr_data_in(gw_data), .gpr_out(gpr));

  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end

  // ****************************************************************
  // Shared helpers
  // ****************************************************************
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [63:0] sb(eag_seg_type s);
    return 64'(int'(s) + 1) << 20;
  endfunction

  function automatic logic [15:0] sl(eag_seg_type s);
    return 16'h0A00 + 16'(s);
  endfunction

  function automatic eag_req_type mk();
    eag_req_type r;
    r = '0;
    r.valid = 1'b1;
    r.ref_kind = EAG_REF_DATA;
    r.mode = EAG_MODE_LEGACY;
    r.asize = EAG_ASZ_32;
    return r;
  endfunction

  function automatic logic [63:0] rd(eag_req_type r, logic [3:0] i);
    if (r.mode == EAG_MODE_LONG64 && r.wide_operand_flag) return gv[i];
    return {{32{gv[i][31]}}, gv[i][31:0]};
  endfunction

  function automatic logic [63:0] ref_eff(eag_req_type r);
    logic [63:0] s;
    case (r.disp_kind)
      EAG_DISP_8: s = {{56{r.disp[7]}}, r.disp[7:0]};
      EAG_DISP_16: s = {{48{r.disp[15]}}, r.disp[15:0]};
      EAG_DISP_32: s = {{32{r.disp[31]}}, r.disp};
      default: s = 64'h0;
    endcase
    if (r.ip_rel) return nip + s;
    if (r.base_en) s = s + rd(r, r.base_idx);
    if (r.index_en && r.index_idx != REG_STACK_PTR) s = s + (rd(r, r.index_idx) << r.scale);
    if (r.asize == EAG_ASZ_16) return {48'h0, s[15:0]};
    if (r.asize == EAG_ASZ_32 || r.mode != EAG_MODE_LONG64) return {32'h0, s[31:0]};
    return s;
  endfunction

  task automatic issue(input eag_req_type r);
    @(posedge clock_in);
    req <= r;
    @(posedge clock_in);
    req.valid <= 1'b0;
    @(posedge clock_in);
    #1;
    check({63'h0, resp.valid}, 64'h1);
  endtask

  task automatic run(input eag_req_type r, input eag_seg_type sg, input logic zb);
    logic [63:0] e;
    e = ref_eff(r);
    issue(r);
    check(resp.eff_addr, e);
    check(64'(resp.seg), 64'(sg));
    check(64'(resp.selector), 64'(sl(sg)));
    check(resp.lin_addr, e + (zb ? 64'h0 : sb(sg)));
    check({63'h0, resp.fault}, 64'(r.index_en && r.index_idx == REG_STACK_PTR));
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_comp();
    eag_req_type r;
    r = mk();
    r.base_idx = 4'h1;
    r.index_idx = 4'h2;
    r.index_en = 1'b1;
    r.disp = 32'h8000_80F0;
    for (int i = 0; i < 32; i++) begin
      r.scale = eag_scale_type'(i[1:0]);
      r.disp_kind = eag_disp_type'(i[3:2]);
      r.base_en = i[4];
      run(r, EAG_SEG_DATA, 1'b0);
    end
    r.index_en = 1'b0;
    run(r, EAG_SEG_DATA, 1'b0);
    r.index_en = 1'b1;
    r.index_idx = REG_STACK_PTR;
    run(r, EAG_SEG_DATA, 1'b0);
  endtask

  task automatic seg_case(input eag_ref_type k, input logic ov, input logic [3:0] b,
                          input eag_seg_type sg);
    eag_req_type r;
    r = mk();
    r.ref_kind = k;
    r.override_en = ov;
    r.override_seg = EAG_SEG_EXTRA_B;
    r.base_en = 1'b1;
    r.base_idx = b;
    run(r, sg, 1'b0);
  endtask

  task automatic t_seg();
    seg_case(EAG_REF_FETCH, 1'b1, 4'h3, EAG_SEG_CODE);
    seg_case(EAG_REF_PUSHPOP, 1'b1, 4'h3, EAG_SEG_STACK);
    seg_case(EAG_REF_STRING_DST, 1'b1, 4'h3, EAG_SEG_STRING);
    seg_case(EAG_REF_DATA, 1'b1, 4'h3, EAG_SEG_EXTRA_B);
    seg_case(EAG_REF_DATA, 1'b0, REG_STACK_PTR, EAG_SEG_STACK);
    seg_case(EAG_REF_DATA, 1'b0, REG_FRAME_PTR, EAG_SEG_STACK);
    seg_case(EAG_REF_DATA, 1'b0, 4'h3, EAG_SEG_DATA);
  endtask

  task automatic t_sizes();
    eag_req_type r;
    r = mk();
    r.asize = EAG_ASZ_16;
    r.base_en = 1'b1;
    r.base_idx = 4'h6;
    r.disp_kind = EAG_DISP_16;
    r.disp = 32'h0000_FF00;
    run(r, EAG_SEG_DATA, 1'b0);
    r.asize = EAG_ASZ_64;
    run(r, EAG_SEG_DATA, 1'b0);
    r.mode = EAG_MODE_COMPAT;
    r.asize = EAG_ASZ_32;
    run(r, EAG_SEG_DATA, 1'b0);
    r.mode = EAG_MODE_LONG64;
    r.asize = EAG_ASZ_64;
    r.base_idx = 4'hF;
    r.index_en = 1'b1;
    r.index_idx = 4'hE;
    r.scale = EAG_SCALE_8;
    run(r, EAG_SEG_DATA, 1'b1);
    r.wide_operand_flag = 1'b1;
    run(r, EAG_SEG_DATA, 1'b1);
    r.override_en = 1'b1;
    r.override_seg = EAG_SEG_EXTRA_A;
    run(r, EAG_SEG_EXTRA_A, 1'b0);
    r.override_en = 1'b0;
    r.ip_rel = 1'b1;
    r.disp_kind = EAG_DISP_32;
    r.disp = 32'hFFFF_FF00;
    run(r, EAG_SEG_DATA, 1'b1);
  endtask

  task automatic t_far();
    eag_req_type r;
    r = mk();
    r.ref_kind = EAG_REF_FAR_PTR;
    issue(r);
    check(resp.eff_addr, 64'h1234_5678);
    check(64'(resp.selector), 64'hBEEF);
    check(64'(resp.seg), 64'(EAG_SEG_DATA));
    check(resp.lin_addr, 64'h1234_5678 + sb(EAG_SEG_DATA));
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    rst_n_in = 1'b0;
    req = '0;
    nip = 64'h0000_7FFF_0000_1000;
    far = 48'hBEEF_1234_5678;
    seg_wr_en = 1'b0;
    seg_wr_idx = EAG_SEG_STRING;
    seg_wr_sel = 16'h0;
    seg_wr_base = 64'h0;
    gw_en = 1'b0;
    gw_idx = 4'h0;
    gw_data = 64'h0;
    errors = 0;
    tests_run = 0;
    @(posedge clock_in);
    #1;
    check({63'h0, resp === '0}, 64'h1);
    @(posedge clock_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      @(posedge clock_in);
      gv[i] = {24'hA5A5A5, 8'(i), 8'h80 + 8'(i), 24'h000123};
      gw_en <= 1'b1;
      gw_idx <= 4'(i);
      gw_data <= gv[i];
    end
    for (int i = 0; i < 6; i++) begin
      @(posedge clock_in);
      gw_en <= 1'b0;
      seg_wr_en <= 1'b1;
      seg_wr_idx <= eag_seg_type'(i);
      seg_wr_sel <= sl(eag_seg_type'(i));
      seg_wr_base <= sb(eag_seg_type'(i));
    end
    @(posedge clock_in);
    seg_wr_en <= 1'b0;
    t_comp();
    t_seg();
    t_sizes();
    t_far();
    end_of_test();
  end

  initial begin
    #50000;
    errors++;
    end_of_test();
  end
endmodule

`default_nettype wire
